/* File: include/aiex_pkg.sv */
// package: constants and carrier types for the add execute block
package aiex_pkg;

  // opcode fields
  localparam logic [7:0]  LIT_OPC_HI     = 8'h0f;
  localparam logic [5:0]  FILE_OPC_HI6   = 6'h09;
  localparam int          OPC_HI6_POS    = 10;
  localparam int          TGT_SEL_POS    = 9;
  localparam int          REGION_POS     = 8;
  // indexed literal offset window top
  localparam logic [7:0]  ILO_LIMIT      = 8'h5f;
  // access bank split: addresses below 60h map to bank 0, 60h and up to bank 15
  localparam logic [7:0]  ACC_SPLIT      = 8'h60;
  localparam logic [3:0]  ACC_HIGH_BANK  = 4'hf;
  // reset values and last phase
  localparam logic [7:0]  ACC_RST        = 8'h00;
  localparam logic [3:0]  BANK_RST       = 4'h0;
  localparam logic [1:0]  PHASE_RST      = 2'h0;
  localparam logic [1:0]  PHASE_LAST     = 2'h3;
  // status bit positions
  localparam int          ST_C  = 0;
  localparam int          ST_DC = 1;
  localparam int          ST_Z  = 2;
  localparam int          ST_OV = 3;
  localparam int          ST_N  = 4;

  typedef enum logic [1:0] {
    AIEX_OP_NONE,
    AIEX_OP_LIT,
    AIEX_OP_FILE
  } aiex_op_t;

  typedef struct packed {
    logic [7:0] sum;
    logic [4:0] flags;
  } aiex_alu_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  data;
    logic        we;
    logic        re;
  } aiex_mem_t;

  typedef struct packed {
    logic [1:0]  phase;
    aiex_op_t    op;
    logic        tgt;
    logic [7:0]  operand;
    logic [7:0]  acc;
    logic [4:0]  status;
    aiex_mem_t   mem;
    logic        busy;
    logic        done;
  } aiex_state_t;

endpackage

/* File: hw/aiex_adder.sv */
// eight bit adder with status flag generation
`timescale 1ns/1ps
`default_nettype none
module aiex_adder
  import aiex_pkg::*;
(
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  output var  aiex_alu_t  res
);
  logic [4:0] low;
  logic [8:0] full;

  always_comb
  begin
    low  = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    full = {1'b0, a} + {1'b0, b};
    res.sum            = full[7:0];
    res.flags          = '0;
    res.flags[ST_C]    = full[8];                        // see RULE_11
    res.flags[ST_DC]   = low[4];                         // see RULE_11
    res.flags[ST_Z]    = (full[7:0] == 8'h00);           // see RULE_11
    res.flags[ST_N]    = full[7];                        // see RULE_11
    // overflow: like-signed operands give an unlike-signed sum
    res.flags[ST_OV]   = (a[7] == b[7]) && (full[7] != a[7]); // see RULE_11
  end
endmodule
`default_nettype wire

/* File: hw/aiex_core.sv */
// add instruction execute unit: four phase decode, read, process, write
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01 - literal add: immediate byte plus accumulator, result into accumulator
// RULE_02 - file add with target select 0 stores sum in accumulator
// RULE_03 - file add with target select 1 writes sum back to file register
// RULE_04 - region bit 0 addresses access bank, bank select ignored
// RULE_05 - region bit 1 uses bank select register to pick the bank
// RULE_06 - extended set, region 0, address up to 5fh: indexed literal offset
// RULE_07 - file add decoded from top six bits 001001, then d, a, address
// RULE_08 - file add updates negative, overflow, carry, digit carry, zero
// RULE_09 - file add is one word and one instruction cycle
// RULE_10 - cycle has four phases: decode, read, process, write in order
// RULE_11 - flags: carry bit7, digit carry bit3, zero, sign bit, signed overflow
module aiex_core
  import aiex_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [15:0] instr,
  input  wire logic        instr_valid,
  input  wire logic        ext_set_en,
  input  wire logic [3:0]  bank_select_reg,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  mem_rdata,
  output logic [11:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             mem_we,
  output logic             mem_re,
  output logic [7:0]       acc,
  output logic [4:0]       status,
  output logic             busy,
  output logic             done,
  output logic [1:0]       phase
);
  aiex_state_t state;
  aiex_state_t next_state;
  aiex_alu_t   alu;
  logic [7:0]  alu_b;
  logic [7:0]  faddr;
  logic [11:0] ea;

  assign alu_b = (state.op == AIEX_OP_LIT) ? state.operand : mem_rdata;

  aiex_adder u_add
  (
    .a   (state.acc),
    .b   (alu_b),
    .res (alu)
  );

  // effective address of the file operand
  always_comb
  begin
    faddr = instr[7:0];
    if (instr[REGION_POS])
    begin
      ea = {bank_select_reg, faddr};                     // see RULE_05
    end
    else if (ext_set_en && (faddr <= ILO_LIMIT))
    begin
      // offset is added to the index base; wraps inside the 4k space
      ea = index_base + {4'h0, faddr};                   // see RULE_06
    end
    else if (faddr < ACC_SPLIT)
    begin
      ea = {BANK_RST, faddr};                            // see RULE_04
    end
    else
    begin
      ea = {ACC_HIGH_BANK, faddr};                       // see RULE_04
    end
  end

  always_comb
  begin
    next_state           = state;
    next_state.done      = 1'b0;
    next_state.mem.we    = 1'b0;
    next_state.mem.re    = 1'b0;
    case (state.phase)
      2'd0:
      begin
        // decode: only taken at the start of a cycle
        next_state.op = AIEX_OP_NONE;
        if (instr_valid)
        begin
          if (instr[15:8] == LIT_OPC_HI)
          begin
            next_state.op      = AIEX_OP_LIT;            // see RULE_01
            next_state.operand = instr[7:0];
          end
          else if (instr[15:OPC_HI6_POS] == FILE_OPC_HI6)
          begin
            next_state.op       = AIEX_OP_FILE;          // see RULE_07
            next_state.tgt      = instr[TGT_SEL_POS];
            next_state.mem.addr = ea;
            next_state.mem.re   = 1'b1;
          end
        end
        next_state.busy  = (next_state.op != AIEX_OP_NONE);
        next_state.phase = 2'd1;                         // see RULE_10
      end
      2'd1:
      begin
        // read: literal already held, file data returned now
        if (state.op == AIEX_OP_FILE)
        begin
          next_state.operand = mem_rdata;
        end
        next_state.phase = 2'd2;                         // see RULE_10
      end
      2'd2:
      begin
        // process: sum and flags registered for the write phase
        if (state.op != AIEX_OP_NONE)
        begin
          next_state.mem.data = alu_b + state.acc;
          next_state.status   = alu.flags;               // see RULE_08
        end
        next_state.phase = PHASE_LAST;                   // see RULE_10
      end
      default:
      begin
        // write: destination updated, instruction ends in this cycle
        case (state.op)
          AIEX_OP_LIT:
          begin
            next_state.acc = state.mem.data;             // see RULE_01
          end
          AIEX_OP_FILE:
          begin
            if (state.tgt)
            begin
              next_state.mem.we = 1'b1;                  // see RULE_03
            end
            else
            begin
              next_state.acc = state.mem.data;           // see RULE_02
            end
          end
          default:
          begin
            next_state.acc = state.acc;
          end
        endcase
        next_state.done  = (state.op != AIEX_OP_NONE);   // see RULE_09
        next_state.busy  = 1'b0;
        next_state.phase = PHASE_RST;
      end
    endcase
  end

  // operand register holds memory data after phase 1, but alu_b takes mem_rdata directly for file adds
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state          <= '0;
      state.op       <= AIEX_OP_NONE;
      state.acc      <= ACC_RST;
      state.phase    <= PHASE_RST;
    end
    else if (clk_en)
    begin
      state <= next_state;
    end
  end

  assign mem_addr  = state.mem.addr;
  assign mem_wdata = state.mem.data;
  assign mem_we    = state.mem.we;
  assign mem_re    = state.mem.re;
  assign acc       = state.acc;
  assign status    = state.status;
  assign busy      = state.busy;
  assign done      = state.done;
  assign phase     = state.phase;
endmodule
`default_nettype wire

/* File: tb/aiex_core_props.sv */
// checker: take-to-done timing and operand addressing of the add unit
`timescale 1ns/1ps
`default_nettype none
module aiex_props (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        clk_en,
  input wire logic [15:0] instr,
  input wire logic        instr_valid,
  input wire logic        ext_set_en,
  input wire logic [3:0]  bank_select_reg,
  input wire logic [11:0] index_base,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_we,
  input wire logic        mem_re,
  input wire logic [7:0]  acc,
  input wire logic        done,
  input wire logic [1:0]  phase
);
  wire [7:0] imm = instr[7:0];
  wire       fil = instr[15:10] == 6'h09;
  wire       tk  = clk_en && phase == 2'h0 && instr_valid && (fil || instr[15:8] == 8'h0f);
  wire       tf  = tk && fil;
  wire       sel = instr[8];
  wire       tgt = instr[9];
  wire       ilo = ext_set_en && imm <= 8'h5f;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_done_lat: assert property (tk |-> ##4 done)
    else $error("done late");
  chk_lit_sum: assert property (
    tk && !fil |-> ##4 acc == $past(acc, 4) + $past(imm, 4)) else $error("literal sum");
  chk_phase_seq: assert property (
    phase == 2'h1 |=> phase == 2'h2 ##1 phase == 2'h3 ##1 phase == 2'h0) else $error("phase");
  chk_read_pulse: assert property (tf |=> mem_re ##1 !mem_re)
    else $error("read pulse");
  chk_bank_addr: assert property (
    tf && sel |=> mem_addr == {$past(bank_select_reg), $past(imm)}) else $error("bank addr");
  chk_access_addr: assert property (
    tf && !sel && !ilo |=> mem_addr == {(($past(imm) > 8'h5f) ? 4'hf : 4'h0), $past(imm)})
    else $error("access addr");
  chk_ilo_addr: assert property (
    tf && !sel && ilo |=> mem_addr == $past(index_base) + $past(imm)) else $error("index addr");
  chk_write_tgt: assert property (tf |-> ##4 mem_we == $past(tgt, 4))
    else $error("write target");
endmodule
bind aiex_core aiex_props i_aiex_props (.clk, .resetn, .clk_en, .instr, .instr_valid,
  .ext_set_en, .bank_select_reg, .index_base, .mem_addr, .mem_we, .mem_re, .acc, .done, .phase);
`default_nettype wire

/* File: tb/tb_aiex_core.sv */
// testbench: literal and file add scenarios for the add unit
`timescale 1ns/1ps
`default_nettype none
module tb_aiex_core;
  logic        clk = 1'b0, resetn = 1'b0, clk_en = 1'b1, instr_valid = 1'b0, ext_set_en = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic [3:0]  bank_select_reg = 4'h0;
  logic [11:0] index_base = 12'h000, mem_addr;
  logic [7:0]  mem_rdata, mem_wdata, acc, ea = 8'h00;
  logic [4:0]  status;
  logic [1:0]  phase;
  logic        mem_we, mem_re, busy, done;
  int          failures = 0, checked = 0;
  always #50 clk = ~clk;
  // file data is a fixed function of the address, so a wrong bank shows in the sum
  assign mem_rdata = mem_addr[7:0] ^ {mem_addr[11:8], 4'h3};
  aiex_core i_aiex_core (.clk, .resetn, .clk_en, .instr, .instr_valid, .ext_set_en,
    .bank_select_reg, .index_base, .mem_rdata, .mem_addr, .mem_wdata, .mem_we, .mem_re,
    .acc, .status, .busy, .done, .phase);
  function automatic logic [4:0] flg(input logic [7:0] a, b);
    logic [8:0] s;
    s = a + b;
    return {s[7], a[7] == b[7] && s[7] != a[7], s[7:0] == 8'h00, a[3:0] + b[3:0] > 5'h0f, s[8]};
  endfunction
  task automatic wrap_up();
    $display("failures %0d checked %0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [13:0] s, e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // held until busy shows the take; bounded so a refused word cannot hang
  task automatic exec(input logic [15:0] w);
    int n = 0;
    @(posedge clk);
    instr <= w;
    instr_valid <= 1'b1;
    do @(negedge clk); while (busy !== 1'b1 && ++n < 9);
    @(posedge clk);
    instr_valid <= 1'b0;
    do @(negedge clk); while (done !== 1'b1 && ++n < 19);
    check({11'h000, busy, phase}, 14'h0000);
  endtask
  task automatic fexec(input logic d, a, input logic [7:0] f, input logic [11:0] ad);
    logic [7:0] op;
    logic [4:0] e;
    op = ad[7:0] ^ {ad[11:8], 4'h3};
    e = flg(ea, op);
    exec({6'h09, d, a, f});
    check({done, mem_we, mem_addr}, {1'b1, d, ad});
    check({1'b0, status, d ? mem_wdata : acc}, {1'b0, e, ea + op});
    if (!d)
      ea = ea + op;
    check({6'h00, acc}, {6'h00, ea});
  endtask
  task automatic t_lit();
    logic [7:0] k[4] = '{8'h15, 8'heb, 8'h7f, 8'h01};
    foreach (k[i])
    begin
      exec({8'h0f, k[i]});
      check({done, acc, status}, {1'b1, ea + k[i], flg(ea, k[i])});
      ea = ea + k[i];
    end
  endtask
  task automatic t_file();
    @(posedge clk);
    bank_select_reg <= 4'h3;
    fexec(1'b0, 1'b1, 8'h20, 12'h320);
    fexec(1'b1, 1'b0, 8'h80, 12'hf80);
    fexec(1'b0, 1'b0, 8'h10, 12'h010);
  endtask
  task automatic t_ilo();
    @(posedge clk);
    ext_set_en <= 1'b1;
    index_base <= 12'h100;
    fexec(1'b1, 1'b0, 8'h5f, 12'h15f);
    fexec(1'b0, 1'b0, 8'h60, 12'hf60);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    t_lit();
    t_file();
    t_ilo();
    wrap_up();
  end
  initial
  begin
    #100000;
    failures++;
    wrap_up();
  end
endmodule
`default_nettype wire
